/* bench/ain_feature_config_sva.sv */
module ain_feature_config_sva
  import ain_feature_pkg::*;
#(
  parameter int WATCHDOG_LIMIT = WATCHDOG_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic xfer_i,
  input wire logic [7:0] ctrl_byte_i,
  input wire logic reply_valid_o,
  input wire logic [7:0] status_byte_o,
  input wire logic [15:0] data_in_o,
  input wire logic watchdog_tripped_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // ****************************************************************
  // cycles since the last exchange, saturating
  // ****************************************************************
  int idle_cnt;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cnt <= 0;
    end else if (xfer_i) begin
      idle_cnt <= 0;
    end else if (idle_cnt < WATCHDOG_LIMIT + 4) begin
      idle_cnt <= idle_cnt + 1;
    end
  end

  // ****************************************************************
  // exchange timing and receipts
  // ****************************************************************
  a_reply_follows_xfer: assert property (xfer_i |=> reply_valid_o)
    else $error("no reply one cycle after exchange");
  a_no_stray_reply: assert property (!xfer_i |=> !reply_valid_o)
    else $error("reply without exchange");
  a_receipt_echo: assert property (xfer_i && ctrl_byte_i[7]
    |=> status_byte_o == ($past(ctrl_byte_i) & 8'hBF))
    else $error("receipt differs from control byte");
  a_write_data_zero: assert property (xfer_i && ctrl_byte_i[7] && ctrl_byte_i[6]
    |=> data_in_o == 16'h0000)
    else $error("write receipt data not zero");
  a_unmapped_reads_zero: assert property (xfer_i && ctrl_byte_i == 8'hBF
    |=> data_in_o == 16'h0000)
    else $error("unmapped register read not zero");
  a_feature_reserved_zero: assert property (xfer_i && ctrl_byte_i == 8'hA0
    |=> (data_in_o & ~FEAT_WRITABLE_MASK) == 16'h0000)
    else $error("reserved feature bits read nonzero");
  a_outputs_hold: assert property (!xfer_i
    |=> $stable(status_byte_o) && $stable(data_in_o))
    else $error("outputs changed without exchange");
  a_process_top_bit: assert property (xfer_i && !ctrl_byte_i[7]
    |=> !status_byte_o[7])
    else $error("process status bit 7 set");
  a_watchdog_not_early: assert property ($rose(watchdog_tripped_o)
    |-> idle_cnt >= WATCHDOG_LIMIT - 1)
    else $error("watchdog tripped too early");
  a_watchdog_cleared: assert property (xfer_i |=> !watchdog_tripped_o)
    else $error("watchdog not cleared by exchange");
endmodule // ain_feature_config_sva

bind ain_feature_config ain_feature_config_sva #(.WATCHDOG_LIMIT(WATCHDOG_LIMIT)) u_sva (
  .clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i),
  .xfer_i(xfer_i),
  .ctrl_byte_i(ctrl_byte_i),
  .reply_valid_o(reply_valid_o),
  .status_byte_o(status_byte_o),
  .data_in_o(data_in_o),
  .watchdog_tripped_o(watchdog_tripped_o)
);

/* bench/coupler_model.sv */
module coupler_model
  import ain_feature_pkg::*;
(
  input wire logic clk_sys_i,
  output logic xfer_o,
  output logic [7:0] ctrl_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle lines after time zero
  initial begin
    xfer_o = 1'b0;
    ctrl_o = 8'h00;
    data_o = 16'h0000;
  end

  // one exchange: held for one edge, then the lines no longer show the word
  task automatic exchange(input logic [7:0] ctrl, input logic [15:0] data);
    @(posedge clk_sys_i);
    xfer_o <= 1'b1;
    ctrl_o <= ctrl;
    data_o <= data;
    @(posedge clk_sys_i);
    xfer_o <= 1'b0;
    ctrl_o <= ~ctrl;
    data_o <= ~data;
  endtask

  // code word first, before any reconfiguration
  task automatic unlock();
    exchange({2'b11, REG_CODE_WORD}, 16'h1235);
  endtask
endmodule // coupler_model

/* bench/testbench.sv */
module testbench;
  import ain_feature_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD_LIMIT = 20;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic unipolar_variant_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic xfer_i, reply_valid_o, watchdog_tripped_o;
  logic [7:0] ctrl_byte_i, status_byte_o;
  logic [15:0] data_out_i, data_in_o, v;
  logic [23:0] exp_q[$];
  int fail_count = 0;
  int tests_run = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  ain_feature_config #(.WATCHDOG_LIMIT(WD_LIMIT)) u_dut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .unipolar_variant_i(unipolar_variant_i),
    .sample_valid_i(sample_valid_i),
    .sample_i(sample_i),
    .xfer_i(xfer_i),
    .ctrl_byte_i(ctrl_byte_i),
    .data_out_i(data_out_i),
    .reply_valid_o(reply_valid_o),
    .status_byte_o(status_byte_o),
    .data_in_o(data_in_o),
    .watchdog_tripped_o(watchdog_tripped_o)
  );

  coupler_model u_cpl (
    .clk_sys_i(clk_sys_i),
    .xfer_o(xfer_i),
    .ctrl_o(ctrl_byte_i),
    .data_o(data_out_i)
  );

  // ****************************************************************
  // checking and reporting
  // ****************************************************************
  task automatic chk(input string name, input logic [23:0] e, input logic [23:0] got);
    tests_run++;
    if (got !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, e, got);
    end
  endtask

  task automatic tally_and_finish();
    if (exp_q.size() != 0) fail_count++;
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reply watcher: oldest noted result against each reply
  always @(negedge clk_sys_i) begin
    if (reply_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("[ERR] reply expected none seen %h", status_byte_o);
      end else begin
        chk("reply", exp_q.pop_front(), {status_byte_o, data_in_o});
      end
    end
  end

  // ****************************************************************
  // driver tasks
  // ****************************************************************
  task automatic rd(input logic [5:0] r, input logic [15:0] e);
    exp_q.push_back({2'b10, r, e});
    u_cpl.exchange({2'b10, r}, 16'h0000);
  endtask

  task automatic wr(input logic [5:0] r, input logic [15:0] d);
    exp_q.push_back({2'b10, r, 16'h0000});
    u_cpl.exchange({2'b11, r}, d);
  endtask

  task automatic sp(input logic [15:0] x, input logic [7:0] s, input logic [15:0] e);
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b1;
    sample_i <= x;
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b0;
    sample_i <= ~x;
    exp_q.push_back({s, e});
    u_cpl.exchange(8'h00, 16'h0000);
  endtask

  // watchdog against a hung run
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    v = 16'($urandom(49498));
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(REG_FEATURE_CONFIGURATION, 16'h0906);
    rd(REG_USER_SCALING_OFFSET, 16'h0000);
    rd(REG_USER_SCALING_GAIN, 16'h0400);
    rd(REG_FIRST_THRESHOLD, 16'h0000);
    rd(REG_SECOND_THRESHOLD, 16'h0000);
    rd(6'h3F, 16'h0000);
    wr(REG_FEATURE_CONFIGURATION, 16'h0000);
    rd(REG_FEATURE_CONFIGURATION, 16'h0906);
    exp_q.push_back({2'b10, REG_CODE_WORD, 16'h0000});
    u_cpl.unlock();
    wr(REG_FEATURE_CONFIGURATION, 16'hFFFF);
    rd(REG_FEATURE_CONFIGURATION, 16'h0F1F);
    wr(REG_FEATURE_CONFIGURATION, 16'h0008);
    sp(16'hFFFF, 8'h00, 16'h8001);
    for (int i = 0; i < 4; i++) begin
      v = 16'(-$urandom_range(1, 1000));
      sp(v, 8'h00, 16'h8000 | (16'h0000 - v));
    end
    wr(REG_FACTORY_GAIN, 16'h0800);
    wr(REG_FEATURE_CONFIGURATION, 16'h0002);
    sp(16'd300, 8'h00, 16'd600);
    wr(REG_FEATURE_CONFIGURATION, 16'h0000);
    sp(16'd300, 8'h00, 16'd300);
    wr(REG_USER_SCALING_GAIN, 16'h0800);
    wr(REG_USER_SCALING_OFFSET, 16'h0005);
    wr(REG_FEATURE_CONFIGURATION, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom_range(0, 1000));
      sp(v, 8'h00, 16'(2 * v + 16'h0005));
    end
    wr(REG_FEATURE_CONFIGURATION, 16'h0000);
    sp(v, 8'h00, v);
    wr(REG_UPPER_RANGE_LIMIT, 16'h0100);
    wr(REG_LOWER_RANGE_LIMIT, 16'hFF00);
    wr(REG_FEATURE_CONFIGURATION, 16'h0100);
    sp(16'h0200, 8'h02, 16'h0100);
    sp(16'hFE00, 8'h01, 16'hFF00);
    wr(REG_FEATURE_CONFIGURATION, 16'h0000);
    sp(16'h0200, 8'h00, 16'h0200);
    wr(REG_FEATURE_CONFIGURATION, 16'h0010);
    sp(16'h0208, 8'h00, 16'h0209);
    sp(16'hFE08, 8'h00, 16'hFE09);
    sp(16'h0017, 8'h00, 16'h0010);
    unipolar_variant_i <= 1'b1;
    sp(16'hFE08, 8'h00, 16'hFE08);
    sp(16'h0208, 8'h00, 16'h0209);
    wr(REG_FIRST_THRESHOLD, 16'd100);
    wr(REG_SECOND_THRESHOLD, 16'hFF9C);
    wr(REG_FEATURE_CONFIGURATION, 16'h0600);
    sp(16'd200, 8'h14, 16'd200);
    sp(16'd0, 8'h18, 16'd0);
    sp(16'hFF38, 8'h28, 16'hFF38);
    wr(REG_FEATURE_CONFIGURATION, 16'h0200);
    sp(16'd200, 8'h04, 16'd200);
    wr(REG_FEATURE_CONFIGURATION, 16'h0000);
    sp(16'd0, 8'h00, 16'd0);
    wr(REG_FEATURE_CONFIGURATION, 16'h0800);
    sp(16'h1000, 8'h00, 16'h0100);
    sp(16'h1000, 8'h00, 16'h01F0);
    wr(REG_FEATURE_CONFIGURATION, 16'h0004);
    repeat (WD_LIMIT / 2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("watchdog", 24'h0, {23'h0, watchdog_tripped_o});
    repeat (WD_LIMIT + 4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("watchdog", 24'h1, {23'h0, watchdog_tripped_o});
    exp_q.push_back({8'h40, 16'h01F0});
    u_cpl.exchange(8'h00, 16'h0000);
    exp_q.push_back({8'h00, 16'h01F0});
    u_cpl.exchange(8'h00, 16'h0000);
    repeat (4) @(posedge clk_sys_i);
    tally_and_finish();
  end
endmodule // testbench

/* rtl/ain_feature_config.sv */
// Operation
// R1: low-pass filter runs only while feature bit 11 is set, else bypassed.
// R2: second threshold is evaluated only while feature bit 10 is set.
// R3: first threshold is evaluated only while feature bit 9 is set.
// R4: range protection clamps to range limits and sets the matching status bit.
// R5: low-bits format puts value in bits 15..3 and status in bits 2..0.
// R6: bipolar variant flags overflow in bit 0 below or above range; bits 2,1 zero.
// R7: unipolar variant flags overflow in bit 0 above range only; bits 2,1 zero.
// R8: bit 3 clear gives two's complement, set gives sign-magnitude output.
// R9: watchdog trips after 100 ms without process data while bit 2 is set.
// R10: factory offset and gain apply while feature bit 1 is set.
// R11: custom offset and gain apply only while feature bit 0 is set.
// R12: custom gain is fixed point, 0x0400 meaning unity.
// R13: custom offset is added in the custom scaling stage.
// R14: value outside a threshold sets the matching status byte bits.
// R15: controller using low-bits format programs custom offset and gain itself.
// R16: reserved feature bits read zero and ignore writes.
// R17: register writes are refused unless code word 0x1235 was written first.
// R18: exceeding the upper range limit shows the limit and sets its status bit.
module ain_feature_config
  import ain_feature_pkg::*;
#(
  parameter int WATCHDOG_LIMIT = WATCHDOG_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic unipolar_variant_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  input wire logic xfer_i,
  input wire logic [7:0] ctrl_byte_i,
  input wire logic [15:0] data_out_i,
  output logic reply_valid_o,
  output logic [7:0] status_byte_o,
  output logic [15:0] data_in_o,
  output logic watchdog_tripped_o
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // saturate a wide signed result to sixteen bits
  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      return 16'h7FFF;
    end else if (v < -34'sd32768) begin
      return 16'h8000;
    end else begin
      return v[15:0];
    end
  endfunction

  // gain times value in fixed point, plus offset
  function automatic logic [15:0] scale(input logic [15:0] x, input logic [15:0] gain,
                                        input logic [15:0] offs);
    logic signed [31:0] prod;
    logic signed [33:0] sum;
    prod = $signed(x) * $signed(gain);
    sum = (34'(prod) >>> GAIN_FRACTION_BITS) + 34'($signed(offs));
    return sat16(sum);
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] feature_configuration;
  logic [15:0] code_word;
  logic [15:0] user_scaling_offset;
  logic [15:0] user_scaling_gain;
  logic [15:0] first_threshold;
  logic [15:0] second_threshold;
  logic [15:0] factory_offset;
  logic [15:0] factory_gain;
  logic [15:0] upper_range_limit;
  logic [15:0] lower_range_limit;

  logic reg_access;
  logic reg_write;
  logic [5:0] reg_num;
  logic write_unlocked;

  assign reg_access = xfer_i && ctrl_byte_i[CTRL_REG_COMM_BIT];
  assign reg_write = reg_access && ctrl_byte_i[CTRL_WRITE_BIT];
  assign reg_num = ctrl_byte_i[5:0];
  assign write_unlocked = (code_word == USER_CODE_WORD); // R17

  // code word register is always writable; any other value relocks
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_word <= CODE_WORD_RESET;
    end else if (reg_write && reg_num == REG_CODE_WORD) begin
      code_word <= data_out_i; // R17
    end
  end

  // protected registers take a write only while unlocked
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      feature_configuration <= FEATURE_RESET;
      user_scaling_offset <= CUSTOM_OFFSET_RESET;
      user_scaling_gain <= CUSTOM_GAIN_RESET;
      first_threshold <= THRESHOLD_RESET;
      second_threshold <= THRESHOLD_RESET;
      factory_offset <= FACTORY_OFFSET_RESET;
      factory_gain <= FACTORY_GAIN_RESET;
      upper_range_limit <= UPPER_RANGE_LIMIT_RESET;
      lower_range_limit <= LOWER_RANGE_LIMIT_RESET;
    end else if (reg_write && write_unlocked) begin // R17
      case (reg_num)
        REG_FEATURE_CONFIGURATION: begin
          feature_configuration <= data_out_i & FEAT_WRITABLE_MASK; // R16
        end
        REG_USER_SCALING_OFFSET: begin
          user_scaling_offset <= data_out_i;
        end
        REG_USER_SCALING_GAIN: begin
          user_scaling_gain <= data_out_i;
        end
        REG_FIRST_THRESHOLD: begin
          first_threshold <= data_out_i;
        end
        REG_SECOND_THRESHOLD: begin
          second_threshold <= data_out_i;
        end
        REG_FACTORY_OFFSET: begin
          factory_offset <= data_out_i;
        end
        REG_FACTORY_GAIN: begin
          factory_gain <= data_out_i;
        end
        REG_UPPER_RANGE_LIMIT: begin
          upper_range_limit <= data_out_i;
        end
        REG_LOWER_RANGE_LIMIT: begin
          lower_range_limit <= data_out_i;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // feature bits
  // ****************************************************************
  logic lowpass_filter_on;
  logic second_threshold_on;
  logic first_threshold_on;
  logic range_protection_on;
  logic status_in_low_bits_format_on;
  logic sign_magnitude_output_on;
  logic process_data_watchdog_on;
  logic factory_scaling_on;
  logic custom_scaling_on;

  assign lowpass_filter_on = feature_configuration[FEAT_LOWPASS_FILTER_ON];
  assign second_threshold_on = feature_configuration[FEAT_SECOND_THRESHOLD_ON];
  assign first_threshold_on = feature_configuration[FEAT_FIRST_THRESHOLD_ON];
  assign range_protection_on = feature_configuration[FEAT_RANGE_PROTECTION_ON];
  assign status_in_low_bits_format_on = feature_configuration[FEAT_STATUS_IN_LOW_BITS_FORMAT_ON];
  assign sign_magnitude_output_on = feature_configuration[FEAT_SIGN_MAGNITUDE_OUTPUT_ON];
  assign process_data_watchdog_on = feature_configuration[FEAT_PROCESS_DATA_WATCHDOG_ON];
  assign factory_scaling_on = feature_configuration[FEAT_FACTORY_SCALING_ON];
  assign custom_scaling_on = feature_configuration[FEAT_CUSTOM_SCALING_ON];

  // ****************************************************************
  // sample datapath: filter, scaling, range, thresholds
  // ****************************************************************
  logic [15:0] filter_state;
  logic [15:0] filtered;
  logic [15:0] factory_scaled;
  logic [15:0] custom_scaled;
  logic over_range;
  logic under_range;
  logic [15:0] limited;

  // first-order low-pass: state moves a fraction of the error each sample
  always_comb begin
    logic signed [33:0] step;
    step = 34'sd0;
    if (lowpass_filter_on) begin // R1
      step = (34'($signed(sample_i)) - 34'($signed(filter_state))) >>> FILTER_SHIFT;
      filtered = sat16(34'($signed(filter_state)) + step);
    end else begin
      filtered = sample_i;
    end
  end

  // filter state follows the raw value while bypassed, so turning on is smooth
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filter_state <= 16'h0000;
    end else if (sample_valid_i) begin
      filter_state <= filtered; // R1
    end
  end

  // factory then custom scaling stages
  always_comb begin
    if (factory_scaling_on) begin // R10
      factory_scaled = scale(filtered, factory_gain, factory_offset);
    end else begin
      factory_scaled = filtered;
    end
    if (custom_scaling_on) begin // R11
      custom_scaled = scale(factory_scaled, user_scaling_gain, user_scaling_offset); // R12 R13
    end else begin
      custom_scaled = factory_scaled;
    end
  end

  // range check and clamp
  always_comb begin
    over_range = $signed(custom_scaled) > $signed(upper_range_limit);
    under_range = $signed(custom_scaled) < $signed(lower_range_limit);
    limited = custom_scaled;
    if (range_protection_on && over_range) begin
      limited = upper_range_limit; // R4 R18
    end else if (range_protection_on && under_range) begin
      limited = lower_range_limit; // R4
    end
  end

  // ****************************************************************
  // output formatting
  // ****************************************************************
  logic [15:0] represented;
  logic [15:0] formatted;
  logic low_bits_overflow;

  always_comb begin
    logic [15:0] magnitude;
    magnitude = 16'h0000;
    if (sign_magnitude_output_on && limited[15]) begin // R8
      magnitude = 16'(-$signed(limited));
      if (magnitude[15]) begin
        represented = 16'hFFFF;
      end else begin
        represented = {1'b1, magnitude[14:0]};
      end
    end else begin
      represented = limited;
    end
  end

  // bipolar flags both directions, unipolar only the upper side
  assign low_bits_overflow = unipolar_variant_i ? over_range // R7
    : (over_range || under_range); // R6

  always_comb begin
    if (status_in_low_bits_format_on) begin // R5
      formatted = {represented[15:3], 2'b00, low_bits_overflow}; // R5 R6 R7
    end else begin
      formatted = represented;
    end
  end

  // ****************************************************************
  // process status and value, latched per sample
  // ****************************************************************
  logic [15:0] process_value;
  logic [5:0] process_flags;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      process_value <= 16'h0000;
      process_flags <= 6'h00;
    end else if (sample_valid_i) begin
      process_value <= formatted;
      process_flags[STAT_OVER_RANGE] <= range_protection_on && over_range; // R4 R18
      process_flags[STAT_UNDER_RANGE] <= range_protection_on && under_range; // R4
      process_flags[STAT_FIRST_ABOVE] <= first_threshold_on &&
        ($signed(limited) > $signed(first_threshold)); // R3 R14
      process_flags[STAT_FIRST_BELOW] <= first_threshold_on &&
        ($signed(limited) < $signed(first_threshold)); // R3 R14
      process_flags[STAT_SECOND_ABOVE] <= second_threshold_on &&
        ($signed(limited) > $signed(second_threshold)); // R2 R14
      process_flags[STAT_SECOND_BELOW] <= second_threshold_on &&
        ($signed(limited) < $signed(second_threshold)); // R2 R14
    end
  end

  // ****************************************************************
  // process data watchdog
  // ****************************************************************
  logic [31:0] watchdog_count;
  logic watchdog_tripped;

  // every exchange from the coupler restarts the count
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      watchdog_count <= 32'h00000000;
      watchdog_tripped <= 1'b0;
    end else if (xfer_i || !process_data_watchdog_on) begin
      watchdog_count <= 32'h00000000;
      watchdog_tripped <= 1'b0;
    end else if (watchdog_count >= 32'(WATCHDOG_LIMIT - 1)) begin
      watchdog_tripped <= 1'b1; // R9
    end else begin
      watchdog_count <= watchdog_count + 32'h00000001; // R9
    end
  end

  assign watchdog_tripped_o = watchdog_tripped;

  // ****************************************************************
  // register read mux
  // ****************************************************************
  logic [15:0] read_value;

  always_comb begin
    case (reg_num)
      REG_CODE_WORD: read_value = code_word;
      REG_FEATURE_CONFIGURATION: read_value = feature_configuration & FEAT_WRITABLE_MASK; // R16
      REG_USER_SCALING_OFFSET: read_value = user_scaling_offset;
      REG_USER_SCALING_GAIN: read_value = user_scaling_gain;
      REG_FIRST_THRESHOLD: read_value = first_threshold;
      REG_SECOND_THRESHOLD: read_value = second_threshold;
      REG_FACTORY_OFFSET: read_value = factory_offset;
      REG_FACTORY_GAIN: read_value = factory_gain;
      REG_UPPER_RANGE_LIMIT: read_value = upper_range_limit;
      REG_LOWER_RANGE_LIMIT: read_value = lower_range_limit;
      default: read_value = 16'h0000;
    endcase
  end

  // ****************************************************************
  // reply to the coupler, one cycle after each exchange
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reply_valid_o <= 1'b0;
      status_byte_o <= 8'h00;
      data_in_o <= 16'h0000;
    end else begin
      reply_valid_o <= xfer_i;
      if (xfer_i && reg_access && ctrl_byte_i[CTRL_WRITE_BIT]) begin
        // write receipt: control byte with the write bit cleared
        status_byte_o <= ctrl_byte_i & 8'hBF;
        data_in_o <= 16'h0000;
      end else if (xfer_i && reg_access) begin
        status_byte_o <= ctrl_byte_i;
        data_in_o <= read_value;
      end else if (xfer_i) begin
        status_byte_o <= {1'b0, watchdog_tripped, process_flags};
        data_in_o <= process_value;
      end
    end
  end

endmodule // ain_feature_config

/* rtl/ain_feature_pkg.sv */
package ain_feature_pkg;

  // ****************************************************************
  // register numbers (six-bit number carried in the control byte)
  // ****************************************************************
  localparam logic [5:0] REG_FACTORY_OFFSET = 6'h13;
  localparam logic [5:0] REG_FACTORY_GAIN = 6'h14;
  localparam logic [5:0] REG_UPPER_RANGE_LIMIT = 6'h15;
  localparam logic [5:0] REG_LOWER_RANGE_LIMIT = 6'h16;
  localparam logic [5:0] REG_CODE_WORD = 6'h1F;
  localparam logic [5:0] REG_FEATURE_CONFIGURATION = 6'h20;
  localparam logic [5:0] REG_USER_SCALING_OFFSET = 6'h21;
  localparam logic [5:0] REG_USER_SCALING_GAIN = 6'h22;
  localparam logic [5:0] REG_FIRST_THRESHOLD = 6'h23;
  localparam logic [5:0] REG_SECOND_THRESHOLD = 6'h24;

  // ****************************************************************
  // control byte fields
  // ****************************************************************
  localparam int CTRL_REG_COMM_BIT = 7;
  localparam int CTRL_WRITE_BIT = 6;

  // ****************************************************************
  // feature register fields
  // ****************************************************************
  localparam int FEAT_LOWPASS_FILTER_ON = 11;
  localparam int FEAT_SECOND_THRESHOLD_ON = 10;
  localparam int FEAT_FIRST_THRESHOLD_ON = 9;
  localparam int FEAT_RANGE_PROTECTION_ON = 8;
  localparam int FEAT_STATUS_IN_LOW_BITS_FORMAT_ON = 4;
  localparam int FEAT_SIGN_MAGNITUDE_OUTPUT_ON = 3;
  localparam int FEAT_PROCESS_DATA_WATCHDOG_ON = 2;
  localparam int FEAT_FACTORY_SCALING_ON = 1;
  localparam int FEAT_CUSTOM_SCALING_ON = 0;
  localparam logic [15:0] FEAT_WRITABLE_MASK = 16'h0F1F;

  // ****************************************************************
  // process status byte fields
  // ****************************************************************
  localparam int STAT_UNDER_RANGE = 0;
  localparam int STAT_OVER_RANGE = 1;
  localparam int STAT_FIRST_ABOVE = 2;
  localparam int STAT_FIRST_BELOW = 3;
  localparam int STAT_SECOND_ABOVE = 4;
  localparam int STAT_SECOND_BELOW = 5;
  localparam int STAT_WATCHDOG = 6;

  // ****************************************************************
  // values after reset and fixed figures
  // ****************************************************************
  localparam logic [15:0] FEATURE_RESET = 16'h0906;
  localparam logic [15:0] CODE_WORD_RESET = 16'h0000;
  localparam logic [15:0] USER_CODE_WORD = 16'h1235;
  localparam logic [15:0] CUSTOM_OFFSET_RESET = 16'h0000;
  localparam logic [15:0] CUSTOM_GAIN_RESET = 16'h0400;
  localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
  localparam logic [15:0] FACTORY_OFFSET_RESET = 16'h0000;
  localparam logic [15:0] FACTORY_GAIN_RESET = 16'h0400;
  localparam logic [15:0] UPPER_RANGE_LIMIT_RESET = 16'h7FFF;
  localparam logic [15:0] LOWER_RANGE_LIMIT_RESET = 16'h8000;
  localparam int GAIN_FRACTION_BITS = 10;
  localparam int FILTER_SHIFT = 4;
  localparam int CLOCK_HZ = 100_000_000;
  localparam int WATCHDOG_TIME_MS = 100;
  localparam int WATCHDOG_CYCLES = (CLOCK_HZ / 1000) * WATCHDOG_TIME_MS;

endpackage : ain_feature_pkg
